/* File: rtl/ccsg_pin_cond.sv */
`timescale 1ns/1ps
module ccsg_pin_cond (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] filter_sel_in,
  ccsg_pin_if.src         pin_out
);
  logic [2:0] sync_reg;
  logic       level_reg;
  logic       rise_reg;
  logic       fall_reg;
  logic [7:0] stable_reg;
  logic [7:0] need;
  logic       agreed;

  always_comb begin
    case (filter_sel_in)
      2'h1:    need = ccsg_pkg::FILT_LEN_1;
      2'h2:    need = ccsg_pkg::FILT_LEN_2;
      2'h3:    need = ccsg_pkg::FILT_LEN_3;
      default: need = ccsg_pkg::FILT_LEN_0;
    endcase
  end

  // Stage one feeds stage two only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], pin_in};
    end
  end

  assign agreed = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg);

  // Filter restarts whenever the new level wavers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      stable_reg <= 8'h00;
      level_reg  <= 1'b0;
      rise_reg   <= 1'b0;
      fall_reg   <= 1'b0;
    end else begin
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      if (!agreed) begin
        stable_reg <= 8'h00;
      end else if (stable_reg >= need) begin
        stable_reg <= 8'h00;
        level_reg  <= sync_reg[2];
        rise_reg   <= sync_reg[2];
        fall_reg   <= !sync_reg[2];
      end else begin
        stable_reg <= stable_reg + 8'h01;
      end
    end
  end

  assign pin_out.level = level_reg;
  assign pin_out.rise  = rise_reg;
  assign pin_out.fall  = fall_reg;
endmodule // ccsg_pin_cond

/* File: rtl/ccsg_pin_if.sv */
`timescale 1ns/1ps
interface ccsg_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface // ccsg_pin_if

/* File: rtl/ccsg_pkg.sv */
package ccsg_pkg;
  // Counter width
  localparam int CW = 32;
  localparam logic [CW-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [CW-1:0] COUNT_ONE   = 32'h0000_0001;
  // Stable cycles demanded by each filter setting
  localparam logic [7:0] FILT_LEN_0 = 8'h00;
  localparam logic [7:0] FILT_LEN_1 = 8'h04;
  localparam logic [7:0] FILT_LEN_2 = 8'h10;
  localparam logic [7:0] FILT_LEN_3 = 8'h40;
  // Pin slots of the conditioner array
  localparam int PIN_PULSE = 0;
  localparam int PIN_SNAP  = 1;
  localparam int PIN_SYNC  = 2;
  localparam int PIN_GATE  = 3;
  localparam int PIN_FI0   = 4;
  localparam int PIN_FI1   = 5;
  localparam int PIN_NUM   = 6;
  typedef enum logic [2:0] {
    MODE_ONE_SHOT,
    MODE_MODULO,
    MODE_FREE_LARGE,
    MODE_EVENT,
    MODE_FREQ
  } ccsg_mode_t;
  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } ccsg_edge_t;
endpackage

/* File: rtl/ccsg_top.sv */
// Notes on behaviour
// - Snapshot enable low: snapshot edges ignored, value and flag kept.
// - Enabled snapshot edge copies the count and raises the snapshot flag.
// - While the snapshot flag is high, further snapshot edges are ignored.
// - Rising acknowledge clears the snapshot flag and re-arms capture.
// - Capture works only in full variant, one-shot, modulo and free-large.
// - Snapshot pin is optional, with selectable filter and trigger edge.
// - Realign flag goes to one when synchronization happens.
// - Synchronization fires on rising transitions only, never on a level.
// - Sync presets one-shot and free-large, zeroes modulo, and starts counting.
// - In event and frequency modes sync restarts the time-base timer.
// - In frequency mode only the realign request input may synchronize.
// - Full variant sync pin is optional and used only when enabled.
// - Simple variant syncs from its sync input, one-shot and modulo only.
// - Gate closed: counting pulses ignored, count held.
// - Gate acts in one-shot and modulo; simple variant uses enable input.
// - Threshold events on crossing threshold 0 and 1, per direction setting.
// - Each fast input flags rising, falling or both edges as configured.
`timescale 1ns/1ps
module ccsg_top (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  full_variant_in,
  input  ccsg_pkg::ccsg_mode_t       mode_in,
  input  wire logic                  count_down_in,
  input  wire logic [31:0]           preset_in,
  input  wire logic [31:0]           modulo_in,
  input  wire logic [31:0]           timebase_in,
  input  wire logic [31:0]           threshold0_in,
  input  wire logic [31:0]           threshold1_in,
  input  wire logic                  th_up_en_in,
  input  wire logic                  th_down_en_in,
  input  wire logic                  pulse_pin_in,
  input  wire logic                  snapshot_pin_in,
  input  wire logic                  snapshot_pin_enable_in,
  input  wire logic [1:0]            snapshot_filter_in,
  input  ccsg_pkg::ccsg_edge_t       snapshot_edge_in,
  input  wire logic                  snapshot_enable_in,
  input  wire logic                  snapshot_ack_in,
  input  wire logic                  sync_pin_in,
  input  wire logic                  sync_pin_enable_in,
  input  wire logic                  realign_req_in,
  input  wire logic                  realign_permit_in,
  input  wire logic                  simple_sync_in,
  input  wire logic                  gate_pin_in,
  input  wire logic                  gate_pin_enable_in,
  input  wire logic                  gate_req_in,
  input  wire logic                  gate_permit_in,
  input  wire logic                  simple_enable_in,
  input  wire logic                  fast_input_zero_in,
  input  wire logic                  fast_input_one_in,
  input  ccsg_pkg::ccsg_edge_t       fi0_edge_in,
  input  ccsg_pkg::ccsg_edge_t       fi1_edge_in,
  output logic [31:0]                count_value_out,
  output logic [31:0]                measure_value_out,
  output logic                       running_out,
  output logic [31:0]                snapshot_value_out,
  output logic                       snapshot_flag_out,
  output logic                       realign_flag_out,
  output logic                       threshold_low_event_out,
  output logic                       threshold_high_event_out,
  output logic                       fast_input_zero_out,
  output logic                       fast_input_one_out
);
  logic [ccsg_pkg::PIN_NUM-1:0] pin_raw;
  logic [ccsg_pkg::PIN_NUM-1:0] pin_lvl;
  logic [ccsg_pkg::PIN_NUM-1:0] pin_rise;
  logic [ccsg_pkg::PIN_NUM-1:0] pin_fall;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        run_reg;
  logic        run_next;
  logic [31:0] tb_reg;
  logic [31:0] meas_reg;
  logic [31:0] snap_reg;
  logic        snap_flag_reg;
  logic        realign_reg;
  logic        th0_reg;
  logic        th1_reg;
  logic        fi0_reg;
  logic        fi1_reg;
  logic        req_d_reg;
  logic        ack_d_reg;
  logic        ssync_d_reg;
  logic        req_rise;
  logic        ack_rise;
  logic        ssync_rise;
  logic        mode_pos;
  logic        mode_tb;
  logic        gate_open;
  logic        sync_trig;
  logic        sync_hit;
  logic        cap_take;
  logic        tb_tick;
  logic        pulse;

  // Edge select shared by snapshot and fast inputs
  function automatic logic edge_hit(input ccsg_pkg::ccsg_edge_t sel,
                                    input logic r, input logic f);
    case (sel)
      ccsg_pkg::EDGE_RISE: edge_hit = r;
      ccsg_pkg::EDGE_FALL: edge_hit = f;
      default:             edge_hit = r | f;
    endcase
  endfunction

  // Crossing in either direction, per direction enables
  function automatic logic crossed(input logic [31:0] prev, input logic [31:0] nxt,
                                   input logic [31:0] th);
    crossed = (th_up_en_in && prev < th && nxt >= th) ||
              (th_down_en_in && prev >= th && nxt < th);
  endfunction

  assign pin_raw = {fast_input_one_in, fast_input_zero_in, gate_pin_in,
                    sync_pin_in, snapshot_pin_in, pulse_pin_in};

  ccsg_pin_if pin_if [ccsg_pkg::PIN_NUM] ();

  genvar gi;
  generate
    for (gi = 0; gi < ccsg_pkg::PIN_NUM; gi++) begin : g_pin
      ccsg_pin_cond u_cond (
        .sys_clk_in    (sys_clk_in),
        .rst_b_in      (rst_b_in),
        .pin_in        (pin_raw[gi]),
        .filter_sel_in ((gi == ccsg_pkg::PIN_SNAP) ? snapshot_filter_in : 2'h0),
        .pin_out       (pin_if[gi])
      );
      assign pin_lvl[gi]  = pin_if[gi].level;
      assign pin_rise[gi] = pin_if[gi].rise;
      assign pin_fall[gi] = pin_if[gi].fall;
    end
  endgenerate

  assign pulse = pin_rise[ccsg_pkg::PIN_PULSE];

  // Control side inputs share our clock, so plain edge registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      req_d_reg   <= 1'b0;
      ack_d_reg   <= 1'b0;
      ssync_d_reg <= 1'b0;
    end else begin
      req_d_reg   <= realign_req_in;
      ack_d_reg   <= snapshot_ack_in;
      ssync_d_reg <= simple_sync_in;
    end
  end

  assign req_rise   = realign_req_in && !req_d_reg;
  assign ack_rise   = snapshot_ack_in && !ack_d_reg;
  assign ssync_rise = simple_sync_in && !ssync_d_reg;

  assign mode_pos = (mode_in == ccsg_pkg::MODE_ONE_SHOT) ||
                    (mode_in == ccsg_pkg::MODE_MODULO) ||
                    (mode_in == ccsg_pkg::MODE_FREE_LARGE);
  assign mode_tb  = (mode_in == ccsg_pkg::MODE_EVENT) ||
                    (mode_in == ccsg_pkg::MODE_FREQ);

  // Synchronization trigger selection
  always_comb begin
    if (full_variant_in) begin
      sync_trig = realign_permit_in &&
                  (req_rise || (sync_pin_enable_in && mode_in != ccsg_pkg::MODE_FREQ &&
                                pin_rise[ccsg_pkg::PIN_SYNC]));
      sync_hit  = sync_trig && (mode_pos || mode_tb);
    end else begin
      sync_trig = ssync_rise;
      sync_hit  = sync_trig && (mode_in == ccsg_pkg::MODE_ONE_SHOT ||
                                mode_in == ccsg_pkg::MODE_MODULO);
    end
  end

  // Gate condition
  always_comb begin
    if (mode_in != ccsg_pkg::MODE_ONE_SHOT && mode_in != ccsg_pkg::MODE_MODULO) begin
      gate_open = 1'b1;
    end else if (full_variant_in) begin
      gate_open = gate_permit_in &&
                  (gate_req_in || (gate_pin_enable_in && pin_lvl[ccsg_pkg::PIN_GATE]));
    end else begin
      gate_open = simple_enable_in;
    end
  end

  assign tb_tick = mode_tb && (tb_reg >= timebase_in - ccsg_pkg::COUNT_ONE);

  // Count update
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (mode_pos && sync_hit) begin
      cnt_next = (mode_in == ccsg_pkg::MODE_MODULO) ? ccsg_pkg::COUNT_RESET : preset_in;
      run_next = 1'b1;
    end else if (mode_pos) begin
      if (pulse && gate_open && run_reg) begin
        case (mode_in)
          ccsg_pkg::MODE_ONE_SHOT: begin
            cnt_next = cnt_reg - ccsg_pkg::COUNT_ONE;
            run_next = (cnt_reg != ccsg_pkg::COUNT_ONE);
          end
          ccsg_pkg::MODE_MODULO: begin
            cnt_next = (cnt_reg >= modulo_in - ccsg_pkg::COUNT_ONE) ?
                       ccsg_pkg::COUNT_RESET : cnt_reg + ccsg_pkg::COUNT_ONE;
          end
          default: begin
            cnt_next = count_down_in ? cnt_reg - ccsg_pkg::COUNT_ONE
                                     : cnt_reg + ccsg_pkg::COUNT_ONE;
          end
        endcase
      end
    end else if (tb_tick) begin
      cnt_next = pulse ? ccsg_pkg::COUNT_ONE : ccsg_pkg::COUNT_RESET;
    end else if (pulse) begin
      cnt_next = cnt_reg + ccsg_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      cnt_reg <= ccsg_pkg::COUNT_RESET;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  // Time base for event and frequency modes
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      tb_reg   <= ccsg_pkg::COUNT_RESET;
      meas_reg <= ccsg_pkg::COUNT_RESET;
    end else if (mode_tb && sync_hit) begin
      tb_reg <= ccsg_pkg::COUNT_RESET;
    end else if (tb_tick) begin
      tb_reg   <= ccsg_pkg::COUNT_RESET;
      meas_reg <= cnt_reg;
    end else if (mode_tb) begin
      tb_reg <= tb_reg + ccsg_pkg::COUNT_ONE;
    end
  end

  assign cap_take = full_variant_in && snapshot_pin_enable_in && snapshot_enable_in &&
                    mode_pos && !snap_flag_reg &&
                    edge_hit(snapshot_edge_in, pin_rise[ccsg_pkg::PIN_SNAP],
                             pin_fall[ccsg_pkg::PIN_SNAP]);

  // Flag can only be low when a capture lands, so set always wins
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      snap_reg      <= ccsg_pkg::COUNT_RESET;
      snap_flag_reg <= 1'b0;
    end else if (cap_take) begin
      snap_reg      <= cnt_reg;
      snap_flag_reg <= 1'b1;
    end else if (ack_rise) begin
      snap_flag_reg <= 1'b0;
    end
  end

  // Event pulses, one cycle each
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      realign_reg <= 1'b0;
      th0_reg     <= 1'b0;
      th1_reg     <= 1'b0;
      fi0_reg     <= 1'b0;
      fi1_reg     <= 1'b0;
    end else begin
      realign_reg <= sync_hit;
      th0_reg     <= !sync_hit && !tb_tick && crossed(cnt_reg, cnt_next, threshold0_in);
      th1_reg     <= !sync_hit && !tb_tick && crossed(cnt_reg, cnt_next, threshold1_in);
      fi0_reg     <= edge_hit(fi0_edge_in, pin_rise[ccsg_pkg::PIN_FI0],
                              pin_fall[ccsg_pkg::PIN_FI0]);
      fi1_reg     <= edge_hit(fi1_edge_in, pin_rise[ccsg_pkg::PIN_FI1],
                              pin_fall[ccsg_pkg::PIN_FI1]);
    end
  end

  assign count_value_out          = cnt_reg;
  assign measure_value_out        = meas_reg;
  assign running_out              = run_reg;
  assign snapshot_value_out       = snap_reg;
  assign snapshot_flag_out        = snap_flag_reg;
  assign realign_flag_out         = realign_reg;
  assign threshold_low_event_out  = th0_reg;
  assign threshold_high_event_out = th1_reg;
  assign fast_input_zero_out      = fi0_reg;
  assign fast_input_one_out       = fi1_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_snap_idle_hold: assert property (
    !snapshot_enable_in |=> $stable(snapshot_value_out))
    else $error("snapshot changed while disabled");
  a_snap_take_value: assert property (
    cap_take |=> snapshot_flag_out && snapshot_value_out == $past(cnt_reg))
    else $error("capture did not store count");
  a_snap_lock_out: assert property (
    snapshot_flag_out && !ack_rise |=> snapshot_flag_out && $stable(snapshot_value_out))
    else $error("flagged capture disturbed");
  a_snap_ack_clear: assert property (
    snapshot_flag_out && ack_rise |=> !snapshot_flag_out)
    else $error("ack did not clear flag");
  a_snap_mode_only: assert property (
    !full_variant_in || !mode_pos |=> $stable(snapshot_value_out))
    else $error("capture outside supported modes");
  a_sync_flag_set: assert property (
    sync_hit |=> realign_flag_out ##1 (!realign_flag_out || $past(sync_hit)))
    else $error("realign flag wrong");
  a_sync_edge_only: assert property (
    realign_req_in && $past(realign_req_in) && !sync_pin_enable_in && full_variant_in
    |=> !realign_flag_out)
    else $error("sync fired on level");
  a_sync_modulo_zero: assert property (
    sync_hit && mode_in == ccsg_pkg::MODE_MODULO |=> cnt_reg == 32'h0000_0000 && run_reg)
    else $error("modulo sync did not zero");
  a_sync_tb_count: assert property (
    sync_hit && mode_tb && !pulse && !tb_tick |=> $stable(cnt_reg) && tb_reg == 32'h0000_0000)
    else $error("timebase sync altered count");
  a_freq_no_pin: assert property (
    full_variant_in && mode_in == ccsg_pkg::MODE_FREQ && !req_rise |=> !realign_flag_out)
    else $error("frequency mode synced from pin");
  a_gate_hold_cnt: assert property (
    mode_pos && !gate_open && !sync_hit |=> $stable(cnt_reg))
    else $error("count moved with gate closed");
  a_fast_zero_evt: assert property (
    fast_input_zero_out |-> $past(pin_rise[ccsg_pkg::PIN_FI0] || pin_fall[ccsg_pkg::PIN_FI0]))
    else $error("fast input event without edge");

  c_capture_ack: cover property (cap_take ##[1:20] ack_rise);
  c_sync_modulo: cover property (sync_hit && mode_in == ccsg_pkg::MODE_MODULO);
  c_th_high: cover property (threshold_high_event_out);
  c_gate_block: cover property (pulse && !gate_open && mode_pos);
endmodule // ccsg_top

/* File: testbench/ccsg_pin_model.sv */
`timescale 1ns/1ps
module ccsg_pin_model (
  input  wire logic       sys_clk_in,
  output logic      [5:0] pins_out
);
  initial pins_out = 6'h00;
  // Pin changes land off the clock edge, as a real async pin would
  task automatic drive(input int idx, input logic val, input int hold);
    @(posedge sys_clk_in);
    #1 pins_out[idx] = val;
    // Hold beyond filter plus sync depth, or the edge is lost
    repeat (hold) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic pulse(input int idx, input int hold);
    drive(idx, 1'b1, hold);
    drive(idx, 1'b0, hold);
  endtask
endmodule // ccsg_pin_model

/* File: testbench/counter_capture_sync_gate_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t %s", $time, m); end end
module counter_capture_sync_gate_bench;
  typedef struct packed {
    logic [5:0]  kind;
    logic        chk;
    logic [31:0] data;
  } ccsg_note_t;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 full = 1'b1;
  ccsg_pkg::ccsg_mode_t mode = ccsg_pkg::MODE_MODULO;
  logic [31:0]          preset = 32'h0000_0000;
  logic                 snap_en = 1'b0;
  logic                 ack = 1'b0;
  logic                 snap_pin_en = 1'b1;
  logic [1:0]           filt = 2'h0;
  ccsg_pkg::ccsg_edge_t snap_edge = ccsg_pkg::EDGE_RISE;
  ccsg_pkg::ccsg_edge_t fi_edge = ccsg_pkg::EDGE_RISE;
  logic                 sync_en = 1'b0;
  logic                 req = 1'b0;
  logic                 permit = 1'b1;
  logic                 ssync = 1'b0;
  logic                 gate_en = 1'b0;
  logic                 gate_req = 1'b1;
  logic                 gate_ok = 1'b1;
  logic                 s_en = 1'b1;
  logic [31:0]          tbase = 32'h0000_0010;
  logic                 cnt_dn = 1'b0;
  logic                 th_dn = 1'b0;
  logic [31:0]          meas;
  logic [5:0]           pins;
  logic [31:0]          cnt;
  logic [31:0]          snapv;
  logic                 run, snapf, rf, thl, thh, f0o, f1o;
  logic                 snap_prev = 1'b0;
  logic [31:0]          seed;
  ccsg_note_t           exp_q[$];
  ccsg_note_t           got, want;
  int                   errors = 0;
  int                   num_checks = 0;
  int                   i, k, e;
  always #2 clk = ~clk;
  ccsg_pin_model i_pins (.sys_clk_in(clk), .pins_out(pins));
  ccsg_top i_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .full_variant_in(full),
    .mode_in(mode), .count_down_in(cnt_dn), .preset_in(preset),
    .modulo_in(32'h0000_0100), .timebase_in(tbase),
    .threshold0_in(32'h0000_0003), .threshold1_in(32'h0000_0005),
    .th_up_en_in(1'b1), .th_down_en_in(th_dn), .pulse_pin_in(pins[0]),
    .snapshot_pin_in(pins[1]), .snapshot_pin_enable_in(snap_pin_en),
    .snapshot_filter_in(filt), .snapshot_edge_in(snap_edge),
    .snapshot_enable_in(snap_en), .snapshot_ack_in(ack), .sync_pin_in(pins[2]),
    .sync_pin_enable_in(sync_en), .realign_req_in(req), .realign_permit_in(permit),
    .simple_sync_in(ssync), .gate_pin_in(pins[3]), .gate_pin_enable_in(gate_en),
    .gate_req_in(gate_req), .gate_permit_in(gate_ok), .simple_enable_in(s_en),
    .fast_input_zero_in(pins[4]), .fast_input_one_in(pins[5]),
    .fi0_edge_in(fi_edge), .fi1_edge_in(fi_edge), .count_value_out(cnt),
    .measure_value_out(meas), .running_out(run), .snapshot_value_out(snapv),
    .snapshot_flag_out(snapf), .realign_flag_out(rf),
    .threshold_low_event_out(thl), .threshold_high_event_out(thh),
    .fast_input_zero_out(f0o), .fast_input_one_out(f1o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report();
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic note(input logic [5:0] kd, input logic c, input logic [31:0] d);
    exp_q.push_back({kd, c, d});
  endtask
  // Long high level must give exactly one sync
  task automatic realign();
    req = 1'b1;
    step(12);
    req = 1'b0;
    step(4);
  endtask
  task automatic pulses(input int n);
    for (int j = 0; j < n; j++) i_pins.pulse(0, 8);
    step(2);
  endtask
  // Event watcher: every pulse output must match the oldest note
  always @(negedge clk) begin
    got.kind = {rf, thl, thh, f0o, f1o, snapf & ~snap_prev};
    got.data = rf ? cnt : snapv;
    snap_prev = snapf;
    if (got.kind !== 6'h00) begin
      if (exp_q.size() == 0) `CHK(got.kind, 6'h00, "unexpected event")
      else begin
        want = exp_q.pop_front();
        `CHK(got.kind, want.kind, "event kind")
        if (want.chk) `CHK(got.data, want.data, "event data")
      end
    end
  end
  initial begin
    #300000;
    errors++;
    final_report();
  end
  initial begin
    seed = 32'h0001_6905;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    `CHK({snapf, rf, run}, 3'h0, "reset outputs")
    step(4);
    note(6'h20, 1'b1, 32'h0);
    realign();
    `CHK(run, 1'b1, "modulo start")
    note(6'h10, 1'b0, 32'h0);
    note(6'h08, 1'b0, 32'h0);
    pulses(6);
    `CHK(cnt, 32'h6, "gate open count")
    gate_req = 1'b0;
    pulses(3);
    `CHK(cnt, 32'h6, "gate closed hold")
    gate_en = 1'b1;
    i_pins.drive(3, 1'b1, 8);
    pulses(2);
    `CHK(cnt, 32'h8, "gate pin open")
    gate_ok = 1'b0;
    pulses(2);
    `CHK(cnt, 32'h8, "permit low hold")
    gate_ok = 1'b1;
    gate_req = 1'b1;
    gate_en = 1'b0;
    i_pins.pulse(1, 8);
    `CHK(snapv, 32'h0, "capture disabled")
    snap_en = 1'b1;
    note(6'h01, 1'b1, 32'h8);
    i_pins.pulse(1, 8);
    pulses(1);
    i_pins.pulse(1, 8);
    `CHK(snapv, 32'h8, "value kept")
    for (k = 0; k < 4; k++) begin
      ack = 1'b1;
      step(2);
      `CHK(snapf, 1'b0, "ack clears")
      ack = 1'b0;
      filt = k[1:0];
      snap_edge = ccsg_pkg::EDGE_FALL;
      note(6'h01, 1'b1, 32'h9);
      i_pins.pulse(1, 72);
    end
    ack = 1'b1;
    snap_pin_en = 1'b0;
    step(2);
    ack = 1'b0;
    i_pins.pulse(1, 72);
    `CHK(snapf, 1'b0, "pin disabled")
    for (e = 0; e < 6; e++) begin
      fi_edge = ccsg_pkg::ccsg_edge_t'(e % 3);
      k = (e < 3) ? 4 : 5;
      if (e % 3 != 1) note(6'h01 << (6 - k), 1'b0, 32'h0);
      if (e % 3 != 0) note(6'h01 << (6 - k), 1'b0, 32'h0);
      i_pins.pulse(k, 8);
    end
    i_pins.pulse(2, 8);
    sync_en = 1'b1;
    note(6'h20, 1'b1, 32'h0);
    i_pins.pulse(2, 8);
    permit = 1'b0;
    realign();
    permit = 1'b1;
    seed = lfsr(seed);
    preset = {16'h0000, seed[15:0]} | 32'h0000_0010;
    mode = ccsg_pkg::MODE_ONE_SHOT;
    note(6'h20, 1'b1, preset);
    realign();
    seed = lfsr(seed);
    k = seed[2:0] + 1;
    pulses(k);
    `CHK(cnt, preset - k, "one-shot down count")
    mode = ccsg_pkg::MODE_FREE_LARGE;
    preset = 32'h0000_0006;
    cnt_dn = 1'b1;
    th_dn = 1'b1;
    note(6'h20, 1'b1, 32'h6);
    realign();
    note(6'h08, 1'b0, 32'h0);
    note(6'h10, 1'b0, 32'h0);
    pulses(4);
    `CHK(cnt, 32'h2, "free-large down count")
    cnt_dn = 1'b0;
    th_dn = 1'b0;
    mode = ccsg_pkg::MODE_FREQ;
    snap_pin_en = 1'b1;
    i_pins.pulse(1, 8);
    // sync pin ignored in frequency mode
    i_pins.pulse(2, 8);
    note(6'h20, 1'b0, 32'h0);
    realign();
    mode = ccsg_pkg::MODE_EVENT;
    tbase = 32'h0000_0080;
    note(6'h20, 1'b0, 32'h0);
    i_pins.pulse(2, 8);
    note(6'h10, 1'b0, 32'h0);
    pulses(3);
    step(70);
    `CHK(meas, 32'h3, "event window count")
    full = 1'b0;
    mode = ccsg_pkg::MODE_MODULO;
    // simple variant syncs from its own input
    realign();
    note(6'h20, 1'b1, 32'h0);
    ssync = 1'b1;
    step(12);
    ssync = 1'b0;
    s_en = 1'b0;
    pulses(2);
    `CHK(cnt, 32'h0, "simple gate closed")
    i_pins.pulse(1, 8);
    for (i = 0; i < 200 && exp_q.size() != 0; i++) step(1);
    `CHK(exp_q.size(), 0, "missing events")
    final_report();
  end
endmodule // counter_capture_sync_gate_bench
